// ===== pkg/gpb_pkg.sv
/*
 Constants for the bitwise-access port block: widths, byte addresses,
 reset values and synchroniser depth.
 Assumes a 32-bit plain register port with byte addresses.
*/
package gpb_pkg;
   localparam int PIN_W = 29;
   localparam int RESV_W = 3;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int SYNC_STAGES = 2;

   localparam logic [ADDR_W-1:0] OFS_FILTERED_PORT = 32'ha0002180;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_RAISE = 32'ha0002200;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_CLEAR = 32'ha0002280;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_INVERT = 32'ha0002300;
   localparam logic [ADDR_W-1:0] OFS_DIRECTION_RAISE = 32'ha0002380;
   localparam logic [ADDR_W-1:0] OFS_DIRECTION_CLEAR = 32'ha0002400;
   localparam logic [ADDR_W-1:0] OFS_DIRECTION_INVERT = 32'ha0002480;

   localparam logic [PIN_W-1:0] OUTPUT_RESET = 29'h0;
   localparam logic [PIN_W-1:0] DIRECTION_RESET = 29'h0;
   localparam logic [PIN_W-1:0] SYNC_RESET = 29'h0;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0;
endpackage

// ===== core/gpb_sync.sv
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes the inputs are asynchronous levels; only stage two is read.
*/
`timescale 1ns/1ns
module gpb_sync #(
   parameter int W = 29
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] stable_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_q <= '0;
         stable_q <= '0;
      end else begin
         meta_q <= async_in;
         stable_q <= meta_q;
      end
   end

   assign sync_out = stable_q;
endmodule

// ===== core/gpb_bitop.sv
/*
 One bit-vector register with filtered load, set, clear and invert.
 Assumes at most one of the four operations is strobed per cycle.
*/
`timescale 1ns/1ns
module gpb_bitop #(
   parameter int W = 29,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic load_en_in,
   input wire logic [W-1:0] load_keep_in,
   input wire logic set_en_in,
   input wire logic clr_en_in,
   input wire logic tog_en_in,
   input wire logic [W-1:0] bits_in,
   output logic [W-1:0] bits_out
);
   logic [W-1:0] bits_q;
   logic [W-1:0] bits_d;
   logic [W-1:0] loaded_w;

   // Kept bits hold their value, others take the written value
   assign loaded_w = (bits_q & load_keep_in) | (bits_in & ~load_keep_in);

   assign bits_d = load_en_in ? loaded_w :
                   set_en_in ? (bits_q | bits_in) :
                   clr_en_in ? (bits_q & ~bits_in) :
                   tog_en_in ? (bits_q ^ bits_in) : bits_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bits_q <= RESET_VAL;
      end else begin
         bits_q <= bits_d;
      end
   end

   assign bits_out = bits_q;
endmodule

// ===== core/gpb_port.sv
/*
 Register logic of a 29-pin general-purpose port: filtered port access,
 atomic raise, clear and invert of output and direction bits, pin drive.
 Rule checks sit at the end of the module, on the bus clock.
 Assumes a plain register port (read data one cycle after the strobe),
 a filter mask and routing enables from same-clock logic, and pins that
 arrive asynchronously.
 At most one strobe per cycle; a write and a read never coincide.
*/
`timescale 1ns/1ns
module gpb_port
   import gpb_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [gpb_pkg::ADDR_W-1:0] bus_addr_in,
   input wire logic [gpb_pkg::DATA_W-1:0] bus_wdata_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   output logic [gpb_pkg::DATA_W-1:0] bus_rdata_out,
   input wire logic [gpb_pkg::PIN_W-1:0] filter_mask_in,
   input wire logic [gpb_pkg::PIN_W-1:0] gpio_route_in,
   input wire logic [gpb_pkg::PIN_W-1:0] port_pin_in,
   output logic [gpb_pkg::PIN_W-1:0] port_pin_out,
   output logic [gpb_pkg::PIN_W-1:0] port_pin_oe_out,
   output logic [gpb_pkg::PIN_W-1:0] output_bits_out,
   output logic [gpb_pkg::PIN_W-1:0] pin_direction_out
);
   import gpb_pkg::*;

   logic [PIN_W-1:0] pin_state_w;
   logic [PIN_W-1:0] output_bits_w;
   logic [PIN_W-1:0] direction_bits_w;
   logic [PIN_W-1:0] wbits_w;
   logic [PIN_W-1:0] filtered_port_bits;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [PIN_W-1:0] port_pin_q;
   logic [PIN_W-1:0] port_pin_oe_q;

   // Exact match on the full byte address; aliases are refused
   wire hit_filtered_w = bus_addr_in == OFS_FILTERED_PORT;
   wire hit_out_raise_w = bus_addr_in == OFS_OUTPUT_RAISE;
   wire hit_out_clear_w = bus_addr_in == OFS_OUTPUT_CLEAR;
   wire hit_out_invert_w = bus_addr_in == OFS_OUTPUT_INVERT;
   wire hit_dir_raise_w = bus_addr_in == OFS_DIRECTION_RAISE;
   wire hit_dir_clear_w = bus_addr_in == OFS_DIRECTION_CLEAR;
   wire hit_dir_invert_w = bus_addr_in == OFS_DIRECTION_INVERT;

   // Any mapped location; all other addresses are ignored
   wire hit_any_w = hit_filtered_w || hit_out_raise_w || hit_out_clear_w
                    || hit_out_invert_w || hit_dir_raise_w || hit_dir_clear_w
                    || hit_dir_invert_w;

   // One strobe per cycle, so at most one write enable is high
   wire wr_filtered_w = bus_wr_in && hit_filtered_w;
   wire wr_out_raise_w = bus_wr_in && hit_out_raise_w;
   wire wr_out_clear_w = bus_wr_in && hit_out_clear_w;
   wire wr_out_invert_w = bus_wr_in && hit_out_invert_w;
   wire wr_dir_raise_w = bus_wr_in && hit_dir_raise_w;
   wire wr_dir_clear_w = bus_wr_in && hit_dir_clear_w;
   wire wr_dir_invert_w = bus_wr_in && hit_dir_invert_w;

   // Pins are asynchronous to the bus clock
   gpb_sync #(
      .W(PIN_W)
   ) u_pin_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .async_in(port_pin_in),
      .sync_out(pin_state_w)
   );

   // Upper bits of every write are dropped here
   assign wbits_w = bus_wdata_in[PIN_W-1:0];

   // Filtered read view of the pins
   assign filtered_port_bits = pin_state_w & ~filter_mask_in;

   // Output bits: filtered load, raise, clear, invert
   gpb_bitop #(
      .W(PIN_W),
      .RESET_VAL(OUTPUT_RESET)
   ) u_output_bits (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .load_en_in(wr_filtered_w),
      .load_keep_in(filter_mask_in),
      .set_en_in(wr_out_raise_w),
      .clr_en_in(wr_out_clear_w),
      .tog_en_in(wr_out_invert_w),
      .bits_in(wbits_w),
      .bits_out(output_bits_w)
   );

   // Direction bits share the same update logic without a load path
   gpb_bitop #(
      .W(PIN_W),
      .RESET_VAL(DIRECTION_RESET)
   ) u_direction_bits (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .load_en_in(1'b0),
      .load_keep_in('1),
      .set_en_in(wr_dir_raise_w),
      .clr_en_in(wr_dir_clear_w),
      .tog_en_in(wr_dir_invert_w),
      .bits_in(wbits_w),
      .bits_out(direction_bits_w)
   );

   // Reserved top bits are constant zero in both readable words
   wire [DATA_W-1:0] filtered_word_w = {{RESV_W{1'b0}}, filtered_port_bits};
   wire [DATA_W-1:0] raise_word_w = {{RESV_W{1'b0}}, output_bits_w};
   wire rd_filtered_w = bus_rd_in && hit_filtered_w;
   wire rd_out_raise_w = bus_rd_in && hit_out_raise_w;

   // Write-only and unmapped locations read as zero
   assign rdata_d = rd_filtered_w ? filtered_word_w :
                    rd_out_raise_w ? raise_word_w :
                    RDATA_RESET;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_q <= RDATA_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Registered pin drive; unrouted or input pins are released
   wire [PIN_W-1:0] port_pin_d = output_bits_w;
   wire [PIN_W-1:0] port_pin_oe_d = direction_bits_w & gpio_route_in;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         port_pin_q <= OUTPUT_RESET;
         port_pin_oe_q <= DIRECTION_RESET;
      end else begin
         port_pin_q <= port_pin_d;
         port_pin_oe_q <= port_pin_oe_d;
      end
   end

   assign bus_rdata_out = rdata_q;
   assign port_pin_out = port_pin_q;
   assign port_pin_oe_out = port_pin_oe_q;
   assign output_bits_out = output_bits_w;
   assign pin_direction_out = direction_bits_w;

   // All checks run on the bus clock; all but the three reset checks pause while reset is high
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   // Reset must win over any pending write
   property p_out_reset;
      disable iff (1'b0)
      rst_in |=> (output_bits_w == OUTPUT_RESET);
   endproperty
   output_reset_a: assert property (p_out_reset)
      else $error("output bits not zero after reset");

   property p_dir_reset;
      disable iff (1'b0)
      rst_in |=> (direction_bits_w == DIRECTION_RESET) && (port_pin_oe_out == '0);
   endproperty
   direction_reset_a: assert property (p_dir_reset)
      else $error("direction bits not zero after reset");

   property p_rdata_pin_reset;
      disable iff (1'b0)
      rst_in |=> (bus_rdata_out == RDATA_RESET) && (port_pin_out == OUTPUT_RESET);
   endproperty
   rdata_pin_reset_a: assert property (p_rdata_pin_reset)
      else $error("read data or pin drive not zero after reset");

   filtered_read_a: assert property (
      bus_rd_in && hit_filtered_w |=>
         bus_rdata_out == {{RESV_W{1'b0}}, $past(pin_state_w) & ~$past(filter_mask_in)})
      else $error("filtered read mismatch");

   filtered_write_a: assert property (
      wr_filtered_w |=>
         output_bits_w == (($past(output_bits_w) & $past(filter_mask_in))
                           | ($past(wbits_w) & ~$past(filter_mask_in))))
      else $error("filtered write touched a filtered bit");

   output_raise_a: assert property (
      wr_out_raise_w |=> output_bits_w == ($past(output_bits_w) | $past(wbits_w)))
      else $error("output raise mismatch");

   raise_read_a: assert property (
      bus_rd_in && hit_out_raise_w |=> bus_rdata_out == {{RESV_W{1'b0}}, output_bits_w})
      else $error("output raise read is not the output bits");

   output_clear_a: assert property (
      wr_out_clear_w |=> output_bits_w == ($past(output_bits_w) & ~$past(wbits_w)))
      else $error("output clear mismatch");

   output_invert_a: assert property (
      wr_out_invert_w |=> output_bits_w == ($past(output_bits_w) ^ $past(wbits_w)))
      else $error("output invert mismatch");

   dir_raise_a: assert property (
      wr_dir_raise_w |=> direction_bits_w == ($past(direction_bits_w) | $past(wbits_w)))
      else $error("direction raise mismatch");

   dir_clear_a: assert property (
      wr_dir_clear_w |=> direction_bits_w == ($past(direction_bits_w) & ~$past(wbits_w)))
      else $error("direction clear mismatch");

   dir_invert_a: assert property (
      wr_dir_invert_w |=> direction_bits_w == ($past(direction_bits_w) ^ $past(wbits_w)))
      else $error("direction invert mismatch");

   write_only_read_a: assert property (
      bus_rd_in && (hit_out_clear_w || hit_out_invert_w || hit_dir_raise_w
                    || hit_dir_clear_w || hit_dir_invert_w) |=> bus_rdata_out == '0)
      else $error("write-only location returned data");

   pin_drive_a: assert property (
      ##1 port_pin_oe_out == ($past(direction_bits_w) & $past(gpio_route_in))
          && port_pin_out == $past(output_bits_w))
      else $error("pin drive does not follow direction and routing");

   reserved_zero_a: assert property (
      bus_rd_in |=> bus_rdata_out[DATA_W-1:PIN_W] == '0)
      else $error("reserved bits read non-zero");

   bits_hold_a: assert property (
      !bus_wr_in |=> $stable(output_bits_w) && $stable(direction_bits_w))
      else $error("bits changed without a write");

   // Read data stands one cycle after the strobe only
   property p_idle_rdata;
      !bus_rd_in
         |=> bus_rdata_out == RDATA_RESET;
   endproperty
   idle_rdata_a: assert property (p_idle_rdata)
      else $error("read data not zero outside a read");

   // Refused accesses leave every bit alone and read as zero
   property p_unmapped_write;
      bus_wr_in && !hit_any_w
         |=> $stable(output_bits_w) && $stable(direction_bits_w);
   endproperty
   unmapped_write_a: assert property (p_unmapped_write)
      else $error("write to an unmapped address changed a bit");

   property p_unmapped_read;
      bus_rd_in && !hit_any_w
         |=> bus_rdata_out == RDATA_RESET;
   endproperty
   unmapped_read_a: assert property (p_unmapped_read)
      else $error("unmapped address returned data");

   // The two registers share the bus but never each other's writes
   property p_out_keeps_dir;
      wr_filtered_w || wr_out_raise_w || wr_out_clear_w || wr_out_invert_w
         |=> $stable(direction_bits_w);
   endproperty
   out_keeps_dir_a: assert property (p_out_keeps_dir)
      else $error("output write changed a direction bit");

   property p_dir_keeps_out;
      wr_dir_raise_w || wr_dir_clear_w || wr_dir_invert_w
         |=> $stable(output_bits_w);
   endproperty
   dir_keeps_out_a: assert property (p_dir_keeps_out)
      else $error("direction write changed an output bit");

   property p_filtered_keep;
      wr_filtered_w
         |=> ((output_bits_w ^ $past(output_bits_w)) & $past(filter_mask_in)) == '0;
   endproperty
   filtered_keep_a: assert property (p_filtered_keep)
      else $error("filtered write changed a filtered bit");

   // Two stages behind the pin; a reset in the last two edges clears them
   property p_pin_sync;
      !$past(rst_in) && !$past(rst_in, 2)
         |-> pin_state_w == $past(port_pin_in, 2);
   endproperty
   pin_sync_a: assert property (p_pin_sync)
      else $error("pin level did not pass two synchroniser stages");

   // Each gate of the pin drive checked on its own
   property p_input_released;
      ##1 (port_pin_oe_out & ~$past(direction_bits_w)) == '0;
   endproperty
   input_released_a: assert property (p_input_released)
      else $error("input pin driven");

   property p_route_gate;
      ##1 (port_pin_oe_out & ~$past(gpio_route_in)) == '0;
   endproperty
   route_gate_a: assert property (p_route_gate)
      else $error("unrouted pin driven");

   filtered_write_c: cover property (wr_filtered_w && filter_mask_in != '0);
   output_invert_c: cover property (wr_out_raise_w ##1 wr_out_invert_w);
   dir_toggle_c: cover property (wr_dir_raise_w ##1 wr_dir_invert_w ##1 wr_dir_clear_w);
   pin_driven_c: cover property (port_pin_oe_out != '0 && port_pin_out != '0);
   unmapped_write_c: cover property (bus_wr_in && !hit_any_w);
endmodule

// ===== tb/gpb_pin_env.sv
/*
 Outside world of the 29 port pins: resolves each pin level.
 Assumes the bench supplies the level that others put on undriven pins.
*/
`timescale 1ns/1ns
module gpb_pin_env
   import gpb_pkg::*;
(
   input wire logic [gpb_pkg::PIN_W-1:0] drive_in,
   input wire logic [gpb_pkg::PIN_W-1:0] oe_in,
   input wire logic [gpb_pkg::PIN_W-1:0] ext_in,
   output logic [gpb_pkg::PIN_W-1:0] level_out
);
   import gpb_pkg::*;
   // Undriven pins show the outside level, never the last driven one
   assign level_out = (drive_in & oe_in) | (ext_in & ~oe_in);
endmodule

// ===== tb/gpb_port_bench.sv
/*
 Self-checking bench for the port block: random bit operations, reads back.
 Assumes the plain register port with read data one cycle after the strobe.
*/
`timescale 1ns/1ns
module gpb_port_bench;
   import gpb_pkg::*;
   logic clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata, d;
   logic [PIN_W-1:0] filt = '0, route = '0, ext = '0, lvl, pin_o, pin_oe, obits, dbits;
   logic [PIN_W-1:0] out_m = '0, dir_m = '0, on_m;
   logic [ADDR_W-1:0] map [7] = '{OFS_OUTPUT_RAISE, OFS_OUTPUT_CLEAR, OFS_OUTPUT_INVERT,
      OFS_DIRECTION_RAISE, OFS_DIRECTION_CLEAR, OFS_DIRECTION_INVERT, OFS_FILTERED_PORT};
   int errors = 0, tests_run = 0, seed = 32'h17a2e10c, k;

   always #25 clk_in = ~clk_in;

   gpb_port DUT (.clk_in(clk_in), .rst_in(rst_in), .bus_addr_in(addr), .bus_wdata_in(wdata),
      .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata), .filter_mask_in(filt),
      .gpio_route_in(route), .port_pin_in(lvl), .port_pin_out(pin_o),
      .port_pin_oe_out(pin_oe), .output_bits_out(obits), .pin_direction_out(dbits));
   gpb_pin_env pins (.drive_in(pin_o), .oe_in(pin_oe), .ext_in(ext), .level_out(lvl));

   task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Leaves the strobe high so a following access can be back to back
   task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic bus_idle();
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      check("read data", rdata, exp);
      @(posedge clk_in);
   endtask

   function automatic logic [2*PIN_W-1:0] model(input int op,
      input logic [PIN_W-1:0] o, dr, v, f);
      case (op)
         0: o = o | v;
         1: o = o & ~v;
         2: o = o ^ v;
         3: dr = dr | v;
         4: dr = dr & ~v;
         5: dr = dr ^ v;
         default: o = (o & f) | (v & ~f);
      endcase
      return {dr, o};
   endfunction

   task automatic end_of_test();
      $display("Checks %0d, errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      check("output bits", {3'h0, obits}, 32'h0);
      check("direction", {3'h0, dbits}, 32'h0);
      bus_rd(OFS_OUTPUT_RAISE, 32'h0);
      // Corner: fully filtered and unmapped writes must change nothing
      filt <= '1;
      bus_wr(OFS_FILTERED_PORT, 32'hffffffff);
      bus_wr(OFS_OUTPUT_RAISE + 32'h4, 32'hffffffff);
      bus_idle();
      check("filtered all", {3'h0, obits}, 32'h0);
      check("unmapped direction", {3'h0, dbits}, 32'h0);
      for (int i = 0; i < 300; i++) begin
         d = $random(seed);
         filt <= d[PIN_W-1:0];
         d = $random(seed);
         route <= d[PIN_W-1:0];
         d = $random(seed);
         ext <= d[PIN_W-1:0];
         repeat (2) begin
            k = $unsigned($random(seed)) % 7;
            d = $random(seed);
            bus_wr(map[k], d);
            {dir_m, out_m} = model(k, out_m, dir_m, d[PIN_W-1:0], filt);
         end
         bus_rd(OFS_OUTPUT_RAISE, {3'h0, out_m});
         check("output bits", {3'h0, obits}, {3'h0, out_m});
         check("direction", {3'h0, dbits}, {3'h0, dir_m});
         check("pin enable", {3'h0, pin_oe}, {3'h0, dir_m & route});
         check("pin drive", {3'h0, pin_o & pin_oe}, {3'h0, out_m & dir_m & route});
         repeat (3) bus_idle();
         on_m = dir_m & route;
         bus_rd(OFS_FILTERED_PORT, {3'h0, ((out_m & on_m) | (ext & ~on_m)) & ~filt});
         k = 1 + i % 6;
         // Write-only places and one unmapped word read as zero
         bus_rd(k == 6 ? OFS_OUTPUT_RAISE + 32'h4 : map[k], 32'h0);
      end
      // Reset in mid-run must clear whatever the loop left behind
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      check("output bits", {3'h0, obits}, 32'h0);
      check("direction", {3'h0, dbits}, 32'h0);
      bus_rd(OFS_OUTPUT_RAISE, 32'h0);
      end_of_test();
   end
endmodule
